// file: dma_bus_master_cycle.sv
// bus master cycle generator: request, strobes, counters, timeout and overrun guard
//
// Overview of operation
// R1 - all cycle logic is one synchronous machine on the bus clock.
// R2 - transfer request edge sets latch unless bus error; bus request follows next edge.
// R3 - count counter steps with address counter; overrun when count is all ones.
// R4 - request bus from arbiter active low; strobes start only after grant.
// R5 - write to memory: read enable at grant, write command one clock later.
// R6 - write command held until transfer acknowledge arrives.
// R7 - transfer acknowledge is synchronised before the machine samples it.
// R8 - read enable latches on and stays until after write command negates.
// R9 - read from memory: write strobe and read command assert at grant.
// R10 - data register captures bus data at the first clock after the trailing edge of its strobe.
// R11 - write strobe drops combinationally on acknowledge; read command one clock later.
// R12 - request cleared in last strobe clock, clear pulse only while clock low.
// R13 - counters increment once, or twice in pack mode, right after the strobe.
// R14 - end state marks cycle finish; second state gives the second increment.
// R15 - timeout asserts after 128 clocks without acknowledge.
// R16 - timeout acts as acknowledge so the cycle completes normally.
// R17 - timeout rising edge sets sticky bus error; requests ignored while set.
// R18 - bus error raises interrupt only when interrupt enable is set.
// R19 - bus error readable as status, cleared only by board reset.
// R20 - timeout counter enabled by register access, not by grant.
// R21 - software loads count with ones complement of maximum byte count.
// R22 - cycle started during overrun floats only the two command outputs.
// R23 - overrun cycle still steps count past all ones to zero or one.
// R24 - system address bus driven only while grant is active.
// R25 - byte transfers big endian; address bit zero marks the lower byte.
// R26 - reset clears latch, error flag, states; strobes and request inactive.
`timescale 1ns/10ps
module dma_bus_master_cycle
  import dma_cycle_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // request side from the adapter control logic
  input wire logic transfer_request,
  input wire logic io_dir,
  input wire logic byte_pack_mode,
  input wire logic register_access_n,
  // arbiter handshake, same clock as the core
  output logic bus_request_n,
  output logic request_clear_n,
  input wire logic bus_grant,
  // memory command pins and acknowledge
  output cmd_pins_t cmd_pins,
  input wire logic xack_n,
  // system address pins
  output addr_pins_t addr_pins,
  // data register strobes and contents
  output logic data_read_en,
  output logic data_write_strobe_n,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic [DATA_W-1:0] data_reg,
  // software load of the counters
  input wire logic addr_load,
  input wire logic [ADDR_W-1:0] addr_load_value,
  input wire logic count_load,
  input wire logic [COUNT_W-1:0] count_load_value,
  // status and control bits
  input wire logic irq_enable,
  output logic [COUNT_W-1:0] transfer_count,
  output logic count_overrun,
  output logic cycle_timeout,
  output logic bus_error_flag,
  output logic irq
);

  cycle_state_t state;
  cycle_state_t next_state;
  logic xreq_sync;
  logic xreq_prev;
  logic xack_raw;
  logic xack_sync;
  logic request_latched;
  logic ack;
  logic cycle_start;
  logic strobe_last;
  logic increment;
  logic overrun_cycle;
  logic timeout_prev;
  logic [TMO_W-1:0] tmo_count;
  logic [ADDR_W-1:0] byte_addr;
  logic mwtc_cmd_n;
  logic mrdc_cmd_n;
  logic [SYS_ADDR_W-1:0] sys_addr;
  logic lower_byte;
  logic high_enable;

  // acknowledge arrives from the bus, active low on the pin
  assign xack_raw = ~xack_n;

  // acknowledge synchroniser, the machine sees only the second stage
  sync_two_flop u_xack_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(xack_raw), // R7
    .sync_out(xack_sync)
  );

  // transfer request comes from outside this clock, so synchronise it first
  sync_two_flop u_xreq_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(transfer_request),
    .sync_out(xreq_sync)
  );

  // timeout stands in for a missing acknowledge
  assign ack = xack_sync | cycle_timeout; // R16

  // a cycle starts once the arbiter grants our pending request
  assign cycle_start = (state == ST_IDLE) && !bus_request_n && bus_grant; // R4

  // last clock of either command strobe, acknowledge seen
  assign strobe_last = ((state == ST_WR_CMD) || (state == ST_RD_CMD)) && ack; // R12

  // counters step in the end state and, in pack mode, the second state
  assign increment = (state == ST_CYCLE_END) || (state == ST_SECOND_INC); // R13

  // edge memory for the request input
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xreq_prev <= 1'b0;
    end else begin
      xreq_prev <= xreq_sync;
    end
  end

  // request latch: set by a rising edge, cleared once bus request is out
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      request_latched <= 1'b0; // R26
    end else if (xreq_sync && !xreq_prev && !bus_error_flag) begin
      request_latched <= 1'b1; // R2 R17
    end else if (!bus_request_n) begin
      request_latched <= 1'b0;
    end
  end

  // bus request: asserted the edge after the latch, dropped at the last strobe clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_request_n <= 1'b1; // R26
    end else if (strobe_last) begin
      bus_request_n <= 1'b1; // R12
    end else if (request_latched) begin
      bus_request_n <= 1'b0; // R2 R4
    end
  end

  // clear pulse shown only in the low half of the clock for the arbiter
  assign request_clear_n = ~(strobe_last & ~core_clk); // R12

  // next state of the cycle machine
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cycle_start) begin
          next_state = io_dir ? ST_WR_SETUP : ST_RD_CMD; // R5 R9
        end
      end
      ST_WR_SETUP: begin
        next_state = ST_WR_CMD; // R5
      end
      ST_WR_CMD: begin
        if (ack) begin
          next_state = ST_CYCLE_END; // R6
        end
      end
      ST_RD_CMD: begin
        if (ack) begin
          next_state = ST_CYCLE_END; // R11
        end
      end
      ST_CYCLE_END: begin
        next_state = byte_pack_mode ? ST_SECOND_INC : ST_IDLE; // R14
      end
      ST_SECOND_INC: begin
        next_state = ST_IDLE; // R14
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register on the bus clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE; // R26
    end else begin
      state <= next_state; // R1
    end
  end

  // memory write command, registered, held until acknowledge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mwtc_cmd_n <= 1'b1; // R26
    end else begin
      mwtc_cmd_n <= ~(next_state == ST_WR_CMD); // R5 R6
    end
  end

  // memory read command, registered, so it trails the write strobe by a clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mrdc_cmd_n <= 1'b1; // R26
    end else begin
      mrdc_cmd_n <= ~(next_state == ST_RD_CMD); // R9 R11
    end
  end

  // overrun guard: a cycle begun at all ones floats the command drivers only,
  // no slave answers and the timeout ends the cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overrun_cycle <= 1'b0;
    end else if (cycle_start) begin
      overrun_cycle <= count_overrun; // R22
    end else if (next_state == ST_IDLE) begin
      overrun_cycle <= 1'b0;
    end
  end

  // command pins in one bundle, one driver; enables low while driving
  assign cmd_pins = '{mwtc_n: mwtc_cmd_n, mwtc_oe_n: overrun_cycle,
                      mrdc_n: mrdc_cmd_n, mrdc_oe_n: overrun_cycle}; // R22

  // read enable latches on at grant and holds past the write command
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_read_en <= 1'b0;
    end else if (cycle_start && io_dir) begin
      data_read_en <= 1'b1; // R5
    end else if (next_state == ST_IDLE) begin
      data_read_en <= 1'b0; // R8
    end
  end

  // write strobe is combinational so it drops the moment acknowledge shows
  assign data_write_strobe_n = ~((state == ST_RD_CMD) && !ack); // R11 R9

  // capture at the first clock after the strobe's trailing edge, as the read state ends
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= DATA_RESET;
    end else if ((state == ST_RD_CMD) && ack) begin
      data_reg <= bus_data_in; // R10
    end
  end

  // address counter, loaded by software, stepped once per byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      byte_addr <= ADDR_RESET;
    end else if (addr_load) begin
      byte_addr <= addr_load_value;
    end else if (increment) begin
      byte_addr <= byte_addr + ADDR_STEP; // R13
    end
  end

  // count counter moves in tandem; software preloads the ones complement
  // of its limit, so the limit itself ends at all ones without error
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_count <= COUNT_RESET;
    end else if (count_load) begin
      transfer_count <= count_load_value; // R21
    end else if (increment) begin
      transfer_count <= transfer_count + COUNT_STEP; // R3 R23
    end
  end

  // carry out of the count counter
  assign count_overrun = (transfer_count == COUNT_ALL_ONES); // R3

  // address pins registered from the counter; grant alone decides the drive
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sys_addr <= '0;
      lower_byte <= 1'b0;
      high_enable <= 1'b0;
    end else begin
      sys_addr <= byte_addr[SYS_ADDR_W-1:0];
      lower_byte <= byte_addr[0] & ~byte_pack_mode; // R25
      high_enable <= byte_pack_mode | ~byte_addr[0]; // R25
    end
  end

  // address drivers on only under grant, received otherwise
  assign addr_pins = '{addr: sys_addr, addr_oe_n: ~bus_grant,
                       a00: lower_byte, bhen: high_enable}; // R24

  // timeout counter runs while a register access is pending; grant may
  // stay up between cycles, so it cannot serve as the enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_count <= '0;
    end else if (register_access_n) begin
      tmo_count <= '0; // R20
    end else if (tmo_count != TIMEOUT_PERIODS) begin
      tmo_count <= tmo_count + TMO_STEP; // R15
    end
  end

  // timeout flag raised once the count has reached its limit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycle_timeout <= 1'b0;
      timeout_prev <= 1'b0;
    end else begin
      cycle_timeout <= !register_access_n && (tmo_count == TIMEOUT_PERIODS); // R15
      timeout_prev <= cycle_timeout;
    end
  end

  // sticky bus error, only reset clears it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_error_flag <= 1'b0; // R19 R26
    end else if (cycle_timeout && !timeout_prev) begin
      bus_error_flag <= 1'b1; // R17
    end
  end

  // interrupt gated by the enable bit
  assign irq = bus_error_flag & irq_enable; // R18

  // checks on the cycle machine
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_write_cmd_delay: assert property ( // R5
    cycle_start && io_dir |=> data_read_en && cmd_pins.mwtc_n ##1 !cmd_pins.mwtc_n)
    else $error("write command not one clock after read enable");

  a_write_cmd_held: assert property ( // R6
    !cmd_pins.mwtc_n && !ack |=> !cmd_pins.mwtc_n)
    else $error("write command dropped before acknowledge");

  a_read_en_hold: assert property ( // R8
    $rose(cmd_pins.mwtc_n) |-> data_read_en)
    else $error("read enable fell with the write command");

  a_read_start: assert property ( // R9
    cycle_start && !io_dir |=> !cmd_pins.mrdc_n && !data_write_strobe_n)
    else $error("read strobes not asserted at grant");

  a_read_hold: assert property ( // R11
    !cmd_pins.mrdc_n && ack |-> data_write_strobe_n ##1 cmd_pins.mrdc_n)
    else $error("read command hold wrong");

  a_request_drop: assert property ( // R12
    strobe_last |=> bus_request_n)
    else $error("request not cleared at last strobe clock");

  a_request_follow: assert property ( // R2
    request_latched && bus_request_n && !strobe_last |=> !bus_request_n)
    else $error("bus request did not follow latch");

  a_double_step: assert property ( // R13
    (state == ST_CYCLE_END) && byte_pack_mode && !count_load
      |=> transfer_count == $past(transfer_count) + COUNT_STEP ##1
          transfer_count == $past(transfer_count, 2) + 16'h0002)
    else $error("pack mode did not step counters twice");

  a_timeout_count: assert property ( // R15
    $rose(cycle_timeout) |-> $past(tmo_count) == TIMEOUT_PERIODS)
    else $error("timeout at wrong count");

  a_error_sticky: assert property ( // R17
    $rose(cycle_timeout) |=> bus_error_flag ##1 bus_error_flag)
    else $error("bus error not latched by timeout");

  a_error_blocks: assert property ( // R17
    bus_error_flag && !request_latched |=> !request_latched)
    else $error("request latched during bus error");

  a_overrun_float: assert property ( // R22
    cycle_start && count_overrun |=> cmd_pins.mwtc_oe_n && cmd_pins.mrdc_oe_n)
    else $error("command drivers not floated on overrun");

  c_write_cycle: cover property (cycle_start && io_dir ##[1:20] (state == ST_CYCLE_END));
  c_read_cycle: cover property (cycle_start && !io_dir ##[1:20] (state == ST_CYCLE_END));
  c_timeout: cover property ($rose(bus_error_flag));
  c_pack_cycle: cover property ((state == ST_SECOND_INC));

endmodule : dma_bus_master_cycle

// file: dma_cycle_pkg.sv
// shared constants, state codes and pin bundles of the bus master cycle generator
package dma_cycle_pkg;
  localparam int ADDR_W = 24;
  localparam int COUNT_W = 16;
  localparam int SYS_ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int TMO_W = 8;
  localparam logic [TMO_W-1:0] TIMEOUT_PERIODS = 8'h80;
  localparam logic [TMO_W-1:0] TMO_STEP = 8'h01;
  localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  // read strobe hold after the write strobe, one clock at the core rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_HOLD_NS = 10;
  localparam int READ_HOLD_CYCLES = (READ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_SETUP = 3'b001,
    ST_WR_CMD = 3'b010,
    ST_RD_CMD = 3'b011,
    ST_CYCLE_END = 3'b100,
    ST_SECOND_INC = 3'b101
  } cycle_state_t;

  // memory command pins, output enables low while driving
  typedef struct packed {
    logic mwtc_n;
    logic mwtc_oe_n;
    logic mrdc_n;
    logic mrdc_oe_n;
  } cmd_pins_t;

  // system address pins and byte qualifiers
  typedef struct packed {
    logic [SYS_ADDR_W-1:0] addr;
    logic addr_oe_n;
    logic a00;
    logic bhen;
  } addr_pins_t;
endpackage : dma_cycle_pkg

// file: sync_two_flop.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sync_two_flop (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // level in and synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  // first stage is read by the second stage only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sync_two_flop

// file: mem_arbiter_model.sv
// bus arbiter and memory slave model facing the cycle generator
`timescale 1ns/10ps
module mem_arbiter_model
  import dma_cycle_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // arbiter handshake
  input wire logic bus_request_n,
  output logic bus_grant,
  // slave side
  input wire cmd_pins_t cmd_pins,
  input wire logic [3:0] ack_delay,
  input wire logic [DATA_W-1:0] rd_word,
  output logic xack_n,
  output logic register_access_n,
  output logic [DATA_W-1:0] bus_data_in
);
  logic [3:0] wait_cnt;
  logic wr_seen;
  logic rd_seen;
  // a floated strobe reaches no slave, so nobody answers it
  assign wr_seen = ~cmd_pins.mwtc_n & ~cmd_pins.mwtc_oe_n;
  assign rd_seen = ~cmd_pins.mrdc_n & ~cmd_pins.mrdc_oe_n;
  // register access lasts from grant until the request is dropped
  assign register_access_n = ~(bus_grant & ~bus_request_n);
  // outputs move on the falling edge, clear of the sampling edge
  always_ff @(negedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_grant <= 1'h0;
      xack_n <= 1'h1;
      wait_cnt <= 4'h0;
      bus_data_in <= 16'h0000;
    end else begin
      bus_grant <= ~bus_request_n;
      // released data lines keep changing, never hold the last word
      bus_data_in <= rd_seen ? rd_word : ~bus_data_in;
      if (!(wr_seen | rd_seen)) begin
        xack_n <= 1'h1;
        wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
        xack_n <= 1'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : mem_arbiter_model

// file: testbench.sv
// self-checking bench for the bus master cycle generator
`timescale 1ns/10ps
module testbench;
  import dma_cycle_pkg::*;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic transfer_request = 1'h0;
  logic io_dir = 1'h0;
  logic byte_pack_mode = 1'h0;
  logic addr_load = 1'h0;
  logic count_load = 1'h0;
  logic irq_enable = 1'h0;
  logic [ADDR_W-1:0] addr_load_value = 24'h000000;
  logic [COUNT_W-1:0] count_load_value = 16'h0000;
  logic [3:0] ack_delay = 4'h0;
  logic [DATA_W-1:0] rd_word = 16'h0000;
  logic bus_request_n, request_clear_n, bus_grant, xack_n, register_access_n;
  logic data_read_en, data_write_strobe_n, count_overrun, cycle_timeout;
  logic bus_error_flag, irq;
  cmd_pins_t cmd_pins;
  addr_pins_t addr_pins;
  logic [DATA_W-1:0] bus_data_in, data_reg;
  logic [COUNT_W-1:0] transfer_count;
  logic [DATA_W-1:0] exp_q[$];
  logic prev_mwtc = 1'h1;
  logic prev_mrdc = 1'h1;
  logic prev_dws = 1'h1;
  logic clr_seen = 1'h0;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 35;
  int exp_count, exp_addr, n;
  int dre_age = 0;

  always #5 core_clk = ~core_clk;

  dma_bus_master_cycle dma_bus_master_cycle_inst (
    .core_clk, .resetn, .transfer_request, .io_dir, .byte_pack_mode, .register_access_n,
    .bus_request_n, .request_clear_n, .bus_grant, .cmd_pins, .xack_n, .addr_pins,
    .data_read_en, .data_write_strobe_n, .bus_data_in, .data_reg, .addr_load,
    .addr_load_value, .count_load, .count_load_value, .irq_enable, .transfer_count,
    .count_overrun, .cycle_timeout, .bus_error_flag, .irq
  );

  mem_arbiter_model mem_arbiter_model_inst (
    .core_clk, .resetn, .bus_request_n, .bus_grant, .cmd_pins, .ack_delay, .rd_word,
    .xack_n, .register_access_n, .bus_data_in
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic ticks(input int k);
    repeat (k) @(negedge core_clk);
  endtask : ticks

  // bounded wait for the bus request level, cycles left in n
  task automatic wait_req(input logic lvl, input int lim);
    n = 0;
    while (bus_request_n !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_req

  task automatic do_reset;
    resetn = 1'h0;
    ticks(8);
    chk(32'({bus_request_n, cmd_pins.mwtc_n, cmd_pins.mrdc_n, bus_error_flag}), 32'hE);
    chk(32'({data_read_en, transfer_count}), 32'h0);
    resetn = 1'h1;
    ticks(2);
  endtask : do_reset

  task automatic load(input logic [23:0] a, input logic [15:0] c);
    addr_load = 1'h1;
    count_load = 1'h1;
    addr_load_value = a;
    count_load_value = c;
    ticks(1);
    addr_load = 1'h0;
    count_load = 1'h0;
    ticks(1);
    exp_addr = a;
    exp_count = c;
  endtask : load

  // one acknowledged cycle, checked against the bench model
  task automatic xfer(input logic dir, input logic pack);
    io_dir = dir;
    byte_pack_mode = pack;
    ack_delay = 4'($random(seed)) & 4'h3;
    rd_word = 16'($random(seed));
    if (!dir) exp_q.push_back(rd_word);
    clr_seen = 1'h0;
    transfer_request = 1'h1;
    wait_req(1'h0, 20);
    chk(32'(n >= 2 && n <= 6), 32'h1);
    wait_req(1'h1, 100);
    ticks(4);
    transfer_request = 1'h0;
    exp_count = (exp_count + pack + 1) & 32'hFFFF;
    exp_addr = (exp_addr + pack + 1) & 32'hFFFFFF;
    chk(32'(transfer_count), exp_count);
    chk(32'(addr_pins.addr), exp_addr & 32'hFFFFF);
    chk(32'({clr_seen, bus_error_flag}), 32'h2);
    if (!dir) chk(32'(data_reg), 32'(exp_q.pop_front()));
    if (!pack) chk(32'({addr_pins.a00, addr_pins.bhen}), 32'({exp_addr[0], ~exp_addr[0]}));
    ticks(3);
  endtask : xfer

  // cycle started on an exhausted count ends through the timeout
  task automatic overrun(input logic pack);
    chk(32'(count_overrun), 32'h1);
    byte_pack_mode = pack;
    io_dir = 1'h1;
    transfer_request = 1'h1;
    wait_req(1'h0, 20);
    ticks(3);
    chk(32'({cmd_pins.mwtc_oe_n, cmd_pins.mrdc_oe_n, addr_pins.addr_oe_n}), 32'h6);
    n = 3;
    while (cycle_timeout !== 1'h1 && n < 300) begin
      ticks(1);
      n++;
    end
    chk(32'(n >= 128 && n <= 132), 32'h1);
    wait_req(1'h1, 20);
    chk(32'(bus_request_n), 32'h1);
    ticks(4);
    chk(32'(transfer_count), 32'(pack));
    chk(32'({bus_error_flag, irq}), 32'h2);
    irq_enable = 1'h1;
    ticks(1);
    chk(32'(irq), 32'h1);
    transfer_request = 1'h0;
    ticks(3);
    transfer_request = 1'h1;
    ticks(20);
    chk(32'({bus_request_n, bus_error_flag}), 32'h3);
    transfer_request = 1'h0;
    irq_enable = 1'h0;
    do_reset;
    chk(32'(bus_error_flag), 32'h0);
  endtask : overrun

  // strobe ordering watched on every cycle
  always @(negedge core_clk) begin
    if (resetn === 1'h1) begin
      if (cmd_pins.mwtc_n === 1'h0 && prev_mwtc === 1'h1) chk(32'(dre_age), 32'h1);
      if (cmd_pins.mwtc_n === 1'h1 && prev_mwtc === 1'h0) chk(32'(data_read_en), 32'h1);
      if (cmd_pins.mrdc_n === 1'h0 && prev_mrdc === 1'h1) chk(32'(data_write_strobe_n), 32'h0);
      if (data_write_strobe_n === 1'h1 && prev_dws === 1'h0) chk(32'(cmd_pins.mrdc_n), 32'h0);
      chk(32'(addr_pins.addr_oe_n), 32'(!bus_grant));
    end
    dre_age = (data_read_en === 1'h1) ? dre_age + 1 : 0;
    prev_mwtc = cmd_pins.mwtc_n;
    prev_mrdc = cmd_pins.mrdc_n;
    prev_dws = data_write_strobe_n;
  end

  // the clear pulse may only appear in the low clock phase
  always @(negedge request_clear_n) begin
    chk(32'(core_clk), 32'h0);
    clr_seen = 1'h1;
  end

  // hang guard, well beyond the expected run
  initial begin
    #200000;
    bad_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    finish_test;
  end

  initial begin
    do_reset;
    load(24'($random(seed)), 16'($random(seed)) & 16'h7FFF);
    for (int i = 0; i < 8; i++) xfer(i[0], i[1]);
    load(24'h0000FE, ~16'h0003);
    xfer(1'h1, 1'h0);
    xfer(1'h0, 1'h1);
    chk(32'({count_overrun, bus_error_flag}), 32'h2);
    overrun(1'h0);
    load(24'h000010, 16'hFFFF);
    overrun(1'h1);
    finish_test;
  end
endmodule : testbench
